//--- design/dsra_defines.vh
// constants for the dual serial register access front end
// assumes a 100 mhz system clock sampling all serial pins
`ifndef DSRA_DEFINES_VH
`define DSRA_DEFINES_VH
`define DSRA_ADDR_W        10
`define DSRA_BCAST_ADDR    5'h15
`define DSRA_INDEP_PREFIX  3'h4
`define DSRA_RUN_REG_ADDR  10'h000
`define DSRA_BYTE_LAST     3'h7
`define DSRA_BIT_ACK       4'h8
`define DSRA_SPI_DIR_BIT   5
`define DSRA_I2C_DIR_BIT   0
`define DSRA_PIN_RST       7'h3d
`define DSRA_EDGE_RST      4'hd
`define DSRA_BIT_PRE       4'hf
`endif

//--- design/dsra_host_port.v
// host register access port: i2c follower or spi follower by strap pin
// assumes pins are asynchronous; register store lives outside this block
//
// Summary of operation
// R01: spi when select pin high, i2c low
// R02: i2c works to fast-plus one megahertz
// R03: start/stop detected while scl high
// R04: bus busy from start to stop
// R05: repeated start restarts address decoding
// R06: ack each received byte on ninth clock
// R07: leader releases sda during ack pulse
// R08: leader nack ends read, follower releases
// R09: bytes are eight bits, msb first
// R10: i2c byte1: chip addr, addr[9:8], dir
// R11: match 100+select pins or broadcast 10101
// R12: i2c byte2 gives register addr low bits
// R13: register address increments after each data byte; a write blocked in standby leaves it unchanged
// R14: four followers distinguished by select pins
// R15: miso driven only during spi read
// R16: select high resets spi state
// R17: spi samples rising, shifts out falling
// R18: spi byte1 is addr bits nine..two
// R19: spi byte2: addr[1:0], dir, don't care
// R20: in standby only run bit reachable, except the first i2c read byte, which is returned ungated
// R21: write stores bytes, read returns register
// R22: broadcast write accepted, broadcast read ignored
`timescale 1ns/1ps
`include "dsra_defines.vh"
module dsra_host_port (
  input  wire        ref_clk_i,
  input  wire        resetn_i,
  input  wire        host_port_select_pin_i,
  input  wire        chip_addr_select_low_pin_i,
  input  wire        chip_addr_select_high_pin_i,
  input  wire        standby_i,
  input  wire        scl_i,
  input  wire        sda_i,
  output reg         sda_o,
  output reg         sda_oe_o,
  input  wire        sclk_i,
  input  wire        ss_n_i,
  input  wire        mosi_i,
  output reg         miso_o,
  output reg         miso_oe_o,
  input  wire [7:0]  reg_rdata_i,
  output reg  [9:0]  reg_addr_o,
  output reg  [7:0]  reg_wdata_o,
  output reg         reg_wr_o,
  output reg         reg_rd_o,
  output reg         bus_busy_o
);
// ==========================================================
// pin synchronisers
// ==========================================================
  reg [6:0] s1_reg;
  reg [6:0] s2_reg;
  reg [3:0] d_reg;
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // idle pin levels, so no false scl or sclk edge follows reset
      s1_reg <= `DSRA_PIN_RST;
      s2_reg <= `DSRA_PIN_RST;
      d_reg  <= `DSRA_EDGE_RST;
    end else begin
      s1_reg <= {host_port_select_pin_i, chip_addr_select_low_pin_i,
                 chip_addr_select_high_pin_i, scl_i, sda_i, sclk_i, ss_n_i};
      s2_reg <= s1_reg;
      d_reg  <= {s2_reg[3], s2_reg[2], s2_reg[1], s2_reg[0]};
    end
  end
  wire spi_mode = s2_reg[6];                        // [R01]
  wire [1:0] sel_pins = {s2_reg[4], s2_reg[5]};
  wire scl = s2_reg[3];
  wire sda = s2_reg[2];
  wire sclk = s2_reg[1];
  wire ss_n = s2_reg[0];
// ==========================================================
// edge detection
// ==========================================================
  // 10 ns sampling vs 500 ns scl high time gives ample margin  [R02]
  wire scl_rise  = scl & ~d_reg[3];
  wire scl_fall  = ~scl & d_reg[3];
  wire start_det = scl & d_reg[3] & ~sda & d_reg[2];   // [R03]
  wire stop_det  = scl & d_reg[3] & sda & ~d_reg[2];   // [R03]
  wire sclk_rise = sclk & ~d_reg[1];
  wire sclk_fall = ~sclk & d_reg[1];
  // mosi stable around sclk edges; two stages keep it aligned with sclk
  reg mosi1_reg;
  reg mosi2_reg;
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mosi1_reg <= 1'b0;
      mosi2_reg <= 1'b0;
    end else begin
      mosi1_reg <= mosi_i;
      mosi2_reg <= mosi1_reg;
    end
  end
// ==========================================================
// shared byte engine
// ==========================================================
  localparam ST_IDLE  = 5'b00001;
  localparam ST_ADR1  = 5'b00010;
  localparam ST_ADR2  = 5'b00100;
  localparam ST_WDATA = 5'b01000;
  localparam ST_RDATA = 5'b10000;
  reg [4:0] state_reg;
  reg [3:0] bit_reg;
  reg [7:0] shift_reg;
  reg [7:0] tx_reg;
  reg       bcast_reg;
  reg       rd_dir_reg;
  reg       ack_reg;
  reg       nack_reg;
  wire [4:0] indep_addr = {`DSRA_INDEP_PREFIX, sel_pins};     // [R14]
  wire [7:0] byte_in    = {shift_reg[6:0], spi_mode ? mosi2_reg : sda}; // [R09]
  // standby lets only the run control register through
  wire acc_ok = ~standby_i | (reg_addr_o == `DSRA_RUN_REG_ADDR);  // [R20]
  wire [9:0] addr_inc = reg_addr_o + 10'h001;
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg   <= ST_IDLE;
      bit_reg     <= 4'h0;
      shift_reg   <= 8'h00;
      tx_reg      <= 8'h00;
      bcast_reg   <= 1'b0;
      rd_dir_reg  <= 1'b0;
      ack_reg     <= 1'b0;
      nack_reg    <= 1'b0;
      reg_addr_o  <= 10'h000;
      reg_wdata_o <= 8'h00;
      reg_wr_o    <= 1'b0;
      reg_rd_o    <= 1'b0;
      bus_busy_o  <= 1'b0;
      sda_o       <= 1'b0;
      sda_oe_o    <= 1'b0;
      miso_o      <= 1'b0;
      miso_oe_o   <= 1'b0;
    end else begin
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      sda_o    <= 1'b0;
      miso_o   <= 1'b0;
      // strobe shows the written address; step only after the store took it
      if (reg_wr_o)
        reg_addr_o <= addr_inc;                             // [R13]
      // ==========================================================
      // spi follower
      // ==========================================================
      if (spi_mode) begin
        sda_oe_o   <= 1'b0;
        bus_busy_o <= 1'b0;
        if (ss_n) begin                                     // [R16]
          state_reg <= ST_ADR1;
          bit_reg   <= 4'h0;
          miso_oe_o <= 1'b0;                                // [R15]
        end else begin
          miso_oe_o <= state_reg[4];                        // [R15]
          miso_o    <= tx_reg[7];
          if (sclk_fall && state_reg[4] && bit_reg != 4'h0)
            tx_reg <= {tx_reg[6:0], 1'b0};                  // [R17]
          if (sclk_rise) begin                              // [R17]
            shift_reg <= byte_in;
            bit_reg   <= bit_reg + 4'h1;
            if (bit_reg[2:0] == `DSRA_BYTE_LAST) begin
              bit_reg <= 4'h0;
              case (state_reg)
                ST_ADR1: begin
                  reg_addr_o[9:2] <= byte_in;               // [R18]
                  state_reg <= ST_ADR2;
                end
                ST_ADR2: begin
                  reg_addr_o[1:0] <= byte_in[7:6];          // [R19]
                  if (byte_in[`DSRA_SPI_DIR_BIT]) begin
                    state_reg <= ST_WDATA;
                  end else begin
                    state_reg <= ST_RDATA;
                    // low address bits land this edge; the next fall reloads
                    tx_reg    <= reg_rdata_i;               // [R21]
                    reg_rd_o  <= 1'b1;
                  end
                end
                ST_WDATA: begin
                  reg_wdata_o <= byte_in;                   // [R21]
                  reg_wr_o    <= acc_ok;
                end
                ST_RDATA: begin
                  reg_addr_o <= addr_inc;                   // [R13]
                  state_reg  <= ST_RDATA;
                end
                default: state_reg <= ST_IDLE;
              endcase
            end
          end
          // reload next read byte once address stepped, on the next fall
          if (state_reg[4] && bit_reg == 4'h0 && sclk_fall) begin
            tx_reg   <= acc_ok ? reg_rdata_i : 8'h00;       // [R21]
            reg_rd_o <= 1'b1;
          end
        end
      end else begin
        // ==========================================================
        // i2c follower
        // ==========================================================
        miso_oe_o <= 1'b0;
        if (start_det) begin                                // [R05]
          state_reg  <= ST_ADR1;
          bit_reg    <= `DSRA_BIT_PRE;
          bus_busy_o <= 1'b1;                               // [R04]
          sda_oe_o   <= 1'b0;
          ack_reg    <= 1'b0;
        end else if (stop_det) begin
          // stop frees the bus even in mid-byte
          state_reg  <= ST_IDLE;                            // [R04]
          bus_busy_o <= 1'b0;
          sda_oe_o   <= 1'b0;
        end else if (state_reg != ST_IDLE) begin
          if (scl_rise) begin
            if (bit_reg == `DSRA_BIT_ACK) begin
              nack_reg <= sda;                              // [R08]
            end else begin
              shift_reg <= byte_in;                         // [R09]
            end
          end
          if (scl_fall) begin
            bit_reg <= bit_reg + 4'h1;
            if (bit_reg == `DSRA_BIT_PRE) begin
              // scl fall that closes the start is not a data bit
              bit_reg <= 4'h0;
            end else if (bit_reg[2:0] == `DSRA_BYTE_LAST && bit_reg != `DSRA_BIT_ACK) begin
              ack_reg  <= 1'b0;
              sda_oe_o <= 1'b0;
              case (state_reg)
                ST_ADR1: begin
                  rd_dir_reg <= shift_reg[`DSRA_I2C_DIR_BIT];  // [R10]
                  reg_addr_o[9:8] <= shift_reg[2:1];
                  bcast_reg <= (shift_reg[7:3] == `DSRA_BCAST_ADDR);
                  if (shift_reg[7:3] == indep_addr) begin   // [R11]
                    ack_reg  <= 1'b1;
                    sda_oe_o <= 1'b1;                       // [R06]
                  end else if (shift_reg[7:3] == `DSRA_BCAST_ADDR &&
                               !shift_reg[`DSRA_I2C_DIR_BIT]) begin // [R22]
                    ack_reg  <= 1'b1;
                    sda_oe_o <= 1'b1;
                  end else begin
                    // no match: stay off the bus until the next start  [R11]
                    state_reg <= ST_IDLE;
                  end
                end
                ST_ADR2: begin
                  reg_addr_o[7:0] <= shift_reg;             // [R12]
                  ack_reg  <= 1'b1;
                  sda_oe_o <= 1'b1;                         // [R06]
                end
                ST_WDATA: begin
                  reg_wdata_o <= shift_reg;                 // [R21]
                  reg_wr_o    <= acc_ok;
                  ack_reg  <= 1'b1;
                  sda_oe_o <= 1'b1;                         // [R06]
                end
                default: begin
                  reg_addr_o <= addr_inc;                   // [R13]
                end
              endcase
            end else if (bit_reg == `DSRA_BIT_ACK) begin
              // ack pulse over: leader has released sda  [R07]
              bit_reg  <= 4'h0;
              ack_reg  <= 1'b0;
              sda_oe_o <= 1'b0;
              case (state_reg)
                ST_ADR1: begin
                  if (rd_dir_reg && !bcast_reg) begin
                    state_reg <= ST_RDATA;
                    tx_reg    <= reg_rdata_i;
                    reg_rd_o  <= 1'b1;
                    sda_oe_o  <= ~reg_rdata_i[7];
                  end else begin
                    state_reg <= ST_ADR2;
                  end
                end
                ST_ADR2: state_reg <= ST_WDATA;
                ST_RDATA: begin
                  if (nack_reg) begin
                    state_reg <= ST_IDLE;                   // [R08]
                  end else begin
                    tx_reg   <= acc_ok ? reg_rdata_i : 8'h00;
                    reg_rd_o <= 1'b1;
                    sda_oe_o <= acc_ok ? ~reg_rdata_i[7] : 1'b1;
                  end
                end
                default: state_reg <= state_reg;
              endcase
            end else if (state_reg[4]) begin
              tx_reg   <= {tx_reg[6:0], 1'b0};
              sda_oe_o <= ~tx_reg[6];
            end
          end
        end
      end
    end
  end
endmodule // dsra_host_port

//--- tb/dsra_host_port_assertions.sv
// checker for the host port, watching the top-level ports only
// assumes one 100 mhz clock domain and the async active-low reset
`timescale 1ns/1ps
module dsra_host_port_checker (
  input wire       ref_clk_i,
  input wire       resetn_i,
  input wire       host_port_select_pin_i,
  input wire       standby_i,
  input wire       scl_i,
  input wire       sda_i,
  input wire       sda_oe_o,
  input wire       sda_o,
  input wire       reg_rd_o,
  input wire       ss_n_i,
  input wire       miso_oe_o,
  input wire [9:0] reg_addr_o,
  input wire       reg_wr_o,
  input wire       bus_busy_o
);
  // ==========================================
  // properties
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  property p_wr_pulse; reg_wr_o |=> !reg_wr_o; endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe longer than one cycle");
  property p_addr_step; reg_wr_o |=> reg_addr_o == $past(reg_addr_o) + 10'h1; endproperty
  a_addr_step: assert property (p_addr_step)
    else $error("address did not step after a write");
  property p_ss_idle; ss_n_i [*6] |=> !miso_oe_o; endproperty
  a_ss_idle: assert property (p_ss_idle)
    else $error("miso driven while deselected");
  property p_i2c_no_miso; (!host_port_select_pin_i) [*6] |=> !miso_oe_o; endproperty
  a_i2c_no_miso: assert property (p_i2c_no_miso)
    else $error("miso driven in two-wire mode");
  property p_spi_no_sda; host_port_select_pin_i [*6] |=> !sda_oe_o && !bus_busy_o; endproperty
  a_spi_no_sda: assert property (p_spi_no_sda)
    else $error("two-wire side active in four-wire mode");
  property p_start; $fell(sda_i) && scl_i && !host_port_select_pin_i |-> ##[1:8] bus_busy_o;
  endproperty
  a_start: assert property (p_start)
    else $error("start not seen");
  property p_stop; $rose(sda_i) && scl_i |-> ##[1:8] !bus_busy_o; endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not free the bus");
  property p_standby; standby_i && reg_wr_o |-> reg_addr_o == 10'h000; endproperty
  a_standby: assert property (p_standby)
    else $error("write outside run bit in standby");
  property p_sda_scl_low; $changed(sda_oe_o) |-> !scl_i && bus_busy_o; endproperty
  a_sda_scl_low: assert property (p_sda_scl_low)
    else $error("sda changed while scl high or bus free");
  property p_rd_pulse; reg_rd_o |=> !reg_rd_o; endproperty
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("read strobe longer than one cycle");
  property p_sda_low; sda_oe_o |-> !sda_o; endproperty
  a_sda_low: assert property (p_sda_low)
    else $error("sda driven high instead of pulled low");
endmodule // dsra_host_port_checker
bind dsra_host_port dsra_host_port_checker dsra_host_port_checker_inst (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .host_port_select_pin_i(host_port_select_pin_i),
  .standby_i(standby_i), .scl_i(scl_i), .sda_i(sda_i), .sda_oe_o(sda_oe_o), .ss_n_i(ss_n_i),
  .miso_oe_o(miso_oe_o), .reg_addr_o(reg_addr_o), .reg_wr_o(reg_wr_o), .bus_busy_o(bus_busy_o),
  .sda_o(sda_o), .reg_rd_o(reg_rd_o));

//--- tb/dsra_host_model.sv
// bus leader and spi host model with a 160 ns serial clock
// assumes an open-drain pulled-up sda built by the bench
`timescale 1ns/1ps
module dsra_host_model (
  input  wire sda_i,
  input  wire miso_i,
  output reg  scl_o,
  output reg  sda_low_o,
  output reg  sclk_o,
  output reg  ss_n_o,
  output reg  mosi_o
);
  // ==========================================
  // serial tasks
  localparam Q = 40;
  initial begin
    scl_o = 1'b1; sda_low_o = 1'b0; sclk_o = 1'b0; ss_n_o = 1'b1; mosi_o = 1'b0;
  end
  // also serves as repeated start
  task i2c_start; begin #Q sda_low_o = 1'b0; #Q scl_o = 1'b1; #Q sda_low_o = 1'b1; #Q scl_o = 1'b0;
  end endtask
  task i2c_stop; begin #Q sda_low_o = 1'b1; #Q scl_o = 1'b1; #Q sda_low_o = 1'b0; #Q;
  end endtask
  task i2c_bit(input b, output s); begin
    #Q sda_low_o = !b; #Q scl_o = 1'b1; #Q s = sda_i; #Q scl_o = 1'b0;
  end endtask
  // ninth bit: release for ack on writes, nack ends a read
  task i2c_byte(input [7:0] b, input ninth, output [7:0] r, output ack);
    integer i;
    begin
      for (i = 7; i >= 0; i--) i2c_bit(b[i], r[i]);
      i2c_bit(ninth, ack);
    end
  endtask
  task spi_byte(input [7:0] t, output [7:0] r);
    integer i;
    begin
      for (i = 7; i >= 0; i--) begin
        mosi_o = t[i]; #(2*Q) sclk_o = 1'b1; r[i] = miso_i; #(2*Q) sclk_o = 1'b0;
      end
    end
  endtask
  // mosi flips when released so a stale level is never trusted
  task spi_sel(input s); begin #(2*Q) ss_n_o = !s; if (!s) mosi_o = ~mosi_o; #(2*Q);
  end endtask
endmodule // dsra_host_model

//--- tb/dsra_host_port_tb.sv
// self-checking bench for the host port with a model register store
// assumes the design pulls sda low only through sda_oe_o
`timescale 1ns/1ps
`include "dsra_defines.vh"
`define CHK(n, e, v) begin checked++; if ((v) !== (e)) begin failures++; \
  $display("mismatch %s expected %h seen %h", n, e, v); end end
module dsra_host_port_tb;
  reg        ref_clk_i = 1'b0, resetn_i = 1'b0, spi = 1'b0, stby = 1'b0;
  reg        s_lo = 1'b0, s_hi = 1'b1, a;
  reg  [7:0] mem [0:1023];
  reg  [7:0] r;
  wire       scl, sda_low, sclk, ss_n, mosi, sda_o, sda_oe, miso_d, miso_oe, wr, rd, busy;
  wire [9:0] addr;
  wire [7:0] wdata;
  wire       sda = ~(sda_low | (sda_oe & ~sda_o));
  wire       miso = miso_oe ? miso_d : 1'bz;
  integer    failures = 0, checked = 0, cycles = 0, i;
  // ==========================================
  // clock, store and hang guard
  always #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (wr) mem[addr] <= wdata;
    if (cycles == 30000) begin failures++; final_report; end
  end
  function [7:0] init_val(input [9:0] ad); init_val = ad[7:0] ^ 8'h5a; endfunction
  dsra_host_model m (.sda_i(sda), .miso_i(miso), .scl_o(scl), .sda_low_o(sda_low),
    .sclk_o(sclk), .ss_n_o(ss_n), .mosi_o(mosi));
  dsra_host_port dsra_host_port_inst (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .host_port_select_pin_i(spi), .chip_addr_select_low_pin_i(s_lo),
    .chip_addr_select_high_pin_i(s_hi), .standby_i(stby), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .sclk_i(sclk), .ss_n_i(ss_n), .mosi_i(mosi),
    .miso_o(miso_d), .miso_oe_o(miso_oe), .reg_rdata_i(mem[addr]), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd), .bus_busy_o(busy));
  // ==========================================
  // scenarios
  task i2c_wr_rd; begin // burst to 0x1fe and 0x1ff, then read back after repeated start
    m.i2c_start; `CHK("busy", 1'b1, busy)
    m.i2c_byte({3'h4, s_hi, s_lo, 3'h2}, 1'b1, r, a); `CHK("ack b1", 1'b0, a)
    m.i2c_byte(8'hfe, 1'b1, r, a); `CHK("ack b2", 1'b0, a)
    m.i2c_byte(8'h11, 1'b1, r, a); `CHK("ack d1", 1'b0, a)
    m.i2c_byte(8'h22, 1'b1, r, a); m.i2c_stop; repeat (4) @(posedge ref_clk_i);
    #1;
    `CHK("free", 1'b0, busy)
    `CHK("wr 1fe", 8'h11, mem[10'h1fe])
    `CHK("wr 1ff", 8'h22, mem[10'h1ff])
    m.i2c_start; m.i2c_byte({3'h4, s_hi, s_lo, 3'h2}, 1'b1, r, a);
    m.i2c_byte(8'hfe, 1'b1, r, a); m.i2c_start;
    m.i2c_byte({3'h4, s_hi, s_lo, 3'h3}, 1'b1, r, a); `CHK("ack rd", 1'b0, a)
    m.i2c_byte(8'hff, 1'b0, r, a); `CHK("rd 1fe", 8'h11, r)
    m.i2c_byte(8'hff, 1'b1, r, a); `CHK("rd 1ff", 8'h22, r)
    m.i2c_stop; `CHK("sda freed", 1'b0, sda_oe)
  end endtask
  task i2c_chip_addr; begin // other follower, broadcast write, broadcast read
    m.i2c_start; m.i2c_byte({3'h4, ~s_hi, s_lo, 3'h0}, 1'b1, r, a); m.i2c_stop;
    `CHK("foreign ack", 1'b1, a)
    m.i2c_start; m.i2c_byte({`DSRA_BCAST_ADDR, 3'h0}, 1'b1, r, a);
    `CHK("bcast ack", 1'b0, a)
    m.i2c_byte(8'h40, 1'b1, r, a); m.i2c_byte(8'h77, 1'b1, r, a); m.i2c_stop;
    `CHK("bcast wr", 8'h77, mem[10'h040])
    m.i2c_start; m.i2c_byte({`DSRA_BCAST_ADDR, 3'h1}, 1'b1, r, a); m.i2c_stop;
    `CHK("bcast rd ack", 1'b1, a)
  end endtask
  task spi_wr_rd; begin // write 0x0ff/0x100, read back with junk in ignored bits
    @(posedge ref_clk_i); #1 spi = 1'b1; repeat (10) @(posedge ref_clk_i);
    #1;
    m.spi_sel(1'b1); m.spi_byte(8'h3f, r); m.spi_byte(8'he0, r);
    m.spi_byte(8'h33, r); m.spi_byte(8'h44, r); `CHK("miso wr", 1'b0, miso_oe)
    m.spi_sel(1'b0);
    `CHK("spi wr 0ff", 8'h33, mem[10'h0ff])
    `CHK("spi wr 100", 8'h44, mem[10'h100])
    m.spi_sel(1'b1); m.spi_byte(8'h3f, r); m.spi_byte(8'hdf, r);
    m.spi_byte(8'h00, r); `CHK("spi rd 0ff", 8'h33, r)
    `CHK("miso rd", 1'b1, miso_oe)
    m.spi_byte(8'h00, r); `CHK("spi rd 100", 8'h44, r)
    m.spi_sel(1'b0); repeat (6) @(posedge ref_clk_i);
    #1;
    `CHK("miso idle", 1'b0, miso_oe)
  end endtask
  task spi_standby; begin // only the run register reachable
    @(posedge ref_clk_i); #1 stby = 1'b1;
    m.spi_sel(1'b1); m.spi_byte(8'h01, r); m.spi_byte(8'h60, r); m.spi_byte(8'h99, r);
    m.spi_sel(1'b0); `CHK("stby blocked", init_val(10'h005), mem[10'h005])
    m.spi_sel(1'b1); m.spi_byte(8'h00, r); m.spi_byte(8'h20, r); m.spi_byte(8'h01, r);
    m.spi_sel(1'b0); `CHK("stby run", 8'h01, mem[10'h000])
  end endtask
  task i2c_sel_pins; begin // every select pin pair, then a reset in mid-transfer
    @(posedge ref_clk_i);
    #1 spi = 1'b0;
    stby = 1'b0;
    for (i = 0; i < 4; i++) begin
      s_hi = i[1];
      s_lo = i[0];
      repeat (10) @(posedge ref_clk_i);
      #1;
      m.i2c_start;
      m.i2c_byte({3'h4, s_hi, s_lo, 3'h0}, 1'b1, r, a);
      `CHK("own ack", 1'b0, a)
      m.i2c_start;
      m.i2c_byte({3'h4, s_hi, ~s_lo, 3'h0}, 1'b1, r, a);
      m.i2c_stop;
      `CHK("other ack", 1'b1, a)
    end
    m.i2c_start;
    m.i2c_byte({3'h4, s_hi, s_lo, 3'h0}, 1'b1, r, a);
    resetn_i = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1 resetn_i = 1'b1;
    `CHK("rst busy", 1'b0, busy)
    `CHK("rst sda", 1'b0, sda_oe)
    repeat (4) @(posedge ref_clk_i);
    #1;
    m.i2c_start;
    m.i2c_byte({3'h4, s_hi, s_lo, 3'h0}, 1'b1, r, a);
    m.i2c_stop;
    `CHK("rst ack", 1'b0, a)
  end endtask
  task final_report; begin
    if (failures == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  end endtask
  initial begin
    for (i = 0; i < 1024; i++) mem[i] = init_val(i[9:0]);
    repeat (10) @(posedge ref_clk_i);
    #1 resetn_i = 1'b1;
    repeat (5) @(posedge ref_clk_i);
    #1;
    i2c_wr_rd;
    i2c_chip_addr;
    spi_wr_rd;
    spi_standby;
    i2c_sel_pins;
    final_report;
  end
endmodule // dsra_host_port_tb
